// *** src/ptt_top.sv ***
// Periodic tick interval timer with Wishbone register slave
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
module ptt_top #(
  parameter logic [15:0] LF_DIV = ptt_pkg::LF_DIV_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Low-frequency clock sampled as a level
  input  wire logic        lf_clk_pin,
  // Tick request and interrupt
  output logic             tick_irq,
  output logic             irq_o,
  // Gate outputs to the rest of the chip
  output logic             serial0_clock_gate
);

  // Bus decode
  logic        req;
  logic        hit_pcg, hit_ttc, hit_st, hit_mk, hit_md, hit_any;
  logic        wr;
  logic [11:0] idx;

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign idx     = wb_adr_i[ptt_pkg::ADDR_W-1:2];
  assign hit_pcg = (idx == ptt_pkg::PCG2_IDX);
  assign hit_ttc = (idx == ptt_pkg::TTC_IDX);
  assign hit_st  = (idx == ptt_pkg::IRQ_STAT_IDX);
  assign hit_mk  = (idx == ptt_pkg::IRQ_MASK_IDX);
  assign hit_md  = (idx == ptt_pkg::MODE_IDX);
  assign hit_any = hit_pcg | hit_ttc | hit_st | hit_mk | hit_md;
  assign wr      = req & wb_we_i & wb_sel_i[0] & hit_any;

  // Low-frequency clock: synchronised, then edge to one-cycle enable
  logic lf_sync;
  logic lf_edge;

  ptt_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (lf_clk_pin),
    .dout  (lf_sync)
  );

  ptt_edge u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (lf_sync),
    .rise  (lf_edge)
  );

  // Register state
  logic [7:0]  pcg_q, pcg_d;
  logic        run_q, run_d;
  logic [2:0]  sel_q, sel_d;
  logic [7:0]  mode_q, mode_d;
  logic        st_q, st_d;
  logic        mk_q, mk_d;
  logic [ptt_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic        tick_q, tick_d;
  logic        irq_q, irq_d;
  logic [31:0] dat_q, dat_d;
  logic        ack_q, ack_d;
  logic        err_q, err_d;
  logic [15:0] div_q, div_d;

  logic        gate_on;
  logic        osc_on;
  logic        halt;
  logic        lf_en;
  logic        hit_tick;
  logic [ptt_pkg::CNT_W-1:0] cnt_inc;
  logic [ptt_pkg::CNT_W-1:0] ival_mask;

  assign gate_on = pcg_q[ptt_pkg::TICK_GATE_BIT];
  assign osc_on  = mode_q[ptt_pkg::MODE_OSC_BIT];
  // Stop mode or halted sleep freezes the low-frequency domain
  assign halt    = mode_q[ptt_pkg::MODE_STOP_BIT] | mode_q[ptt_pkg::MODE_SLEEP_BIT];

  // Free-running divider wraps at LF_DIV but drives nothing; only pin edges make the timer count
  always_comb begin
    if (div_q == LF_DIV) begin
      div_d = 16'h0000;
    end else begin
      div_d = div_q + 16'h0001;
    end
  end

  // Counting only with gate on, oscillator on and not halted
  assign lf_en = lf_edge & gate_on & osc_on & ~halt;

  // Period 2^(15-n): interval elapses when the low (15-n) bits roll to zero
  always_comb begin
    ival_mask = '1 >> sel_q;
  end

  assign cnt_inc  = cnt_q + {{(ptt_pkg::CNT_W-1){1'b0}}, 1'b1};
  assign hit_tick = lf_en & run_q & ((cnt_inc & ival_mask) == '0);

  // Control and gate registers
  always_comb begin
    pcg_d  = pcg_q;
    run_d  = run_q;
    sel_d  = sel_q;
    mode_d = mode_q;
    mk_d   = mk_q;
    if (wr && hit_pcg) begin
      pcg_d = wb_dat_i[7:0];
    end
    if (wr && hit_md) begin
      mode_d = wb_dat_i[7:0] & 8'h07;
    end
    if (wr && hit_mk) begin
      mk_d = wb_dat_i[0];
    end
    if (wr && hit_ttc) begin
      run_d = wb_dat_i[ptt_pkg::RUN_BIT];
      // Select loads on any write while stopped, whatever the run bit
      if (!run_q && wb_dat_i[ptt_pkg::RUN_BIT]) begin
        sel_d = wb_dat_i[ptt_pkg::SEL_LSB +: ptt_pkg::SEL_W];
      end else if (!run_q) begin
        sel_d = wb_dat_i[ptt_pkg::SEL_LSB +: ptt_pkg::SEL_W];
      end
    end
    // Oscillator off or deep low-power mode forces run off, select retained
    if (!osc_on || halt) begin
      run_d = 1'b0;
    end
  end

  // Counter
  always_comb begin
    cnt_d = cnt_q;
    if (!run_q) begin
      cnt_d = '0;
    end else if (lf_en) begin
      cnt_d = cnt_inc;
    end
  end

  // Tick pulse, sticky status and interrupt
  always_comb begin
    tick_d = hit_tick;
    st_d   = st_q;
    if (wr && hit_st && wb_dat_i[0]) begin
      st_d = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (tick_q) begin
      st_d = 1'b1;
    end
    irq_d = st_d & mk_d;
  end

  // Bus answer: one cycle after request, single-cycle ack or err
  always_comb begin
    dat_d = 32'h0000_0000;
    ack_d = 1'b0;
    err_d = 1'b0;
    if (req) begin
      ack_d = hit_any;
      err_d = ~hit_any;
      if (!wb_we_i) begin
        unique case (1'b1)
          hit_pcg: dat_d[7:0] = pcg_q;
          hit_ttc: dat_d[7:0] = {4'h0, sel_q, run_q};
          hit_st:  dat_d[0]   = st_q;
          hit_mk:  dat_d[0]   = mk_q;
          hit_md:  dat_d[7:0] = mode_q;
          default: dat_d      = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pcg_q  <= ptt_pkg::PCG2_RST;
      run_q  <= ptt_pkg::TTC_RST[ptt_pkg::RUN_BIT];
      sel_q  <= ptt_pkg::TTC_RST[ptt_pkg::SEL_LSB +: ptt_pkg::SEL_W];
      mode_q <= ptt_pkg::MODE_RST;
      st_q   <= 1'b0;
      mk_q   <= 1'b0;
      cnt_q  <= '0;
      tick_q <= 1'b0;
      irq_q  <= 1'b0;
      dat_q  <= 32'h0000_0000;
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      div_q  <= 16'h0000;
    end else begin
      pcg_q  <= pcg_d;
      run_q  <= run_d;
      sel_q  <= sel_d;
      mode_q <= mode_d;
      st_q   <= st_d;
      mk_q   <= mk_d;
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
      irq_q  <= irq_d;
      dat_q  <= dat_d;
      ack_q  <= ack_d;
      err_q  <= err_d;
      div_q  <= div_d;
    end
  end

  assign wb_dat_o           = dat_q;
  assign wb_ack_o           = ack_q;
  assign wb_err_o           = err_q;
  assign tick_irq           = tick_q;
  assign irq_o              = irq_q;
  assign serial0_clock_gate = pcg_q[ptt_pkg::SER0_GATE_BIT];

endmodule

// *** src/ptt_pkg.sv ***
// Package: register map, field layout and constants for the tick interval timer
package ptt_pkg;
  // Register byte offsets (0x0F76 and 0x0FDA are multiples of 2 only, so indexed)
  localparam logic [11:0] PCG2_IDX     = 12'hF76;
  localparam logic [11:0] TTC_IDX      = 12'hFC8;
  localparam logic [11:0] IRQ_STAT_IDX = 12'hFD8;
  localparam logic [11:0] IRQ_MASK_IDX = 12'hFD9;
  localparam logic [11:0] MODE_IDX     = 12'hFDA;
  localparam int          ADDR_W       = 14;
  // Field positions
  localparam int          TICK_GATE_BIT  = 5;
  localparam int          SER0_GATE_BIT  = 0;
  localparam int          RUN_BIT        = 0;
  localparam int          SEL_LSB        = 1;
  localparam int          SEL_W          = 3;
  localparam int          MODE_OSC_BIT   = 0;
  localparam int          MODE_STOP_BIT  = 1;
  localparam int          MODE_SLEEP_BIT = 2;
  // Reset values
  localparam logic [7:0]  PCG2_RST  = 8'h00;
  localparam logic [7:0]  TTC_RST   = 8'h00;
  localparam logic [7:0]  MODE_RST  = 8'h01;
  localparam logic [7:0]  TTC_WMASK = 8'h0F;
  // Counter
  localparam int          CNT_W       = 15;
  localparam int          MAX_EXP     = 15;
  localparam int          CTR_MAX_EXP = 8;
  localparam int          DIV_W       = 16;
  localparam logic [15:0] LF_DIV_DEF  = 16'h0131;
endpackage

// *** src/ptt_sync.sv ***
// Two-flop synchroniser for a level from another clock domain
`timescale 1ns/1ns
module ptt_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level
  input  wire logic din,
  output logic      dout
);
  logic s1_q, s1_d;
  logic s2_q, s2_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign dout = s2_q;
endmodule

// *** src/ptt_edge.sv ***
// Rising-edge detector producing a one-cycle pulse
`timescale 1ns/1ns
module ptt_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in, pulse out
  input  wire logic level,
  output logic      rise
);
  logic prev_q, prev_d;

  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = level & ~prev_q;
endmodule

// *** sim/ptt_chk.sv ***
// Checker: bus handshake, read data and tick pulse assertions
`timescale 1ns/1ns
module ptt_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Timer side
  input wire logic        lf_clk_pin,
  input wire logic        tick_irq,
  input wire logic        irq_o,
  input wire logic        serial0_clock_gate
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctl_a;
  assign ctl_a = wb_adr_i[13:2] == ptt_pkg::TTC_IDX;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_ans;
    wb_ack_o || wb_err_o;
  endsequence
  AST_ANSWER: assert property (s_req |=> s_ans) else $error("no bus answer");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ERR_ONE: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
  AST_EXCL: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  AST_UPPER: assert property (wb_ack_o && !wb_we_i && ctl_a |-> wb_dat_o[7:4] == 4'h0)
    else $error("upper bits set");
  AST_TICK_ONE: assert property (tick_irq |=> !tick_irq [*8])
    else $error("tick too long");
  AST_RST: assert property ($rose(rst_n) |-> !tick_irq && !irq_o && !serial0_clock_gate)
    else $error("outputs after reset");
endmodule
bind ptt_top ptt_chk ptt_chk_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .lf_clk_pin(lf_clk_pin), .tick_irq(tick_irq), .irq_o(irq_o),
  .serial0_clock_gate(serial0_clock_gate));

// *** sim/ptt_top_tb.sv ***
// Testbench: register, tick and interrupt scenarios for the tick timer
`timescale 1ns/1ns
module ptt_top_tb;
  logic        clk, rst_n, cyc, stb, we, lf, ack, err, tick, irq, s0g, e;
  logic [15:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0]  q;
  int          error_cnt, cmp_count, ticks, b;
  localparam logic [11:0] G = ptt_pkg::PCG2_IDX;
  localparam logic [11:0] C = ptt_pkg::TTC_IDX;
  localparam logic [11:0] S = ptt_pkg::IRQ_STAT_IDX;
  localparam logic [11:0] M = ptt_pkg::IRQ_MASK_IDX;
  localparam logic [11:0] D = ptt_pkg::MODE_IDX;
  ptt_top ptt_top_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .lf_clk_pin(lf), .tick_irq(tick), .irq_o(irq),
    .serial0_clock_gate(s0g));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, got);
    end
  endtask
  // Master waits on the answer with a bound; data is taken while ack stands
  task bus(input logic w, input logic [11:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {2'b00, i, 2'b00}; wdat <= {24'h0, d};
    // Answer is judged at the rising edge itself, before the design updates
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    q = rdat[7:0];
    e = err;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task rd(input logic [11:0] i, input logic [7:0] x);
    bus(1'b0, i, 8'h00);
    chk("reg", q, x);
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Four bus cycles per slow edge keeps the synchroniser happy
  task lfp(input int n);
    repeat (2 * n) begin repeat (2) @(posedge clk); lf <= ~lf; end
  endtask
  task intv(input logic [2:0] s);
    int p;
    p = 1 << (15 - s);
    bus(1'b1, C, {4'h0, s, 1'b1});
    b = ticks;
    lfp(p - 1); w(6); chk("early", 8'(ticks - b), 8'h00);
    lfp(1); w(6); chk("tick", 8'(ticks - b), 8'h01);
    lfp(p); w(6); chk("again", 8'(ticks - b), 8'h02);
    bus(1'b1, C, 8'h00);
    rd(C, {4'h0, s, 1'b0});
  endtask
  task t_reset;
    rd(G, 8'h00);
    bus(1'b0, 12'h000, 8'h00); chk("err", {7'h0, e}, 8'h01);
    bus(1'b1, G, 8'hFF); chk("s0g", {7'h0, s0g}, 8'h01);
    rd(G, 8'hFF);
    bus(1'b1, G, 8'h20);
    rd(C, 8'h00);
    $display("reset done");
  endtask
  task t_codes;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, C, {4'h0, 3'(s), 1'b1});
      bus(1'b1, C, {4'h0, ~3'(s), 1'b1});
      rd(C, {4'h0, 3'(s), 1'b1});
      bus(1'b1, C, 8'hF0);
      rd(C, {4'h0, 3'(s), 1'b0});
    end
    $display("codes done");
  endtask
  task t_gate;
    bus(1'b1, G, 8'h00);
    bus(1'b1, C, 8'h0F);
    b = ticks;
    lfp(300); w(6); chk("gated", 8'(ticks - b), 8'h00);
    bus(1'b1, C, 8'h0E);
    bus(1'b1, G, 8'h20);
    $display("gate done");
  endtask
  task t_restart;
    bus(1'b1, C, 8'h0F);
    lfp(100);
    bus(1'b1, C, 8'h0E);
    lfp(20);
    intv(3'h7);
    intv(3'h6);
    $display("restart done");
  endtask
  task t_halt;
    logic [7:0] m [3] = '{8'h00, 8'h03, 8'h05};
    foreach (m[k]) begin
      bus(1'b1, C, 8'h0D);
      bus(1'b1, D, m[k]);
      rd(C, 8'h0C);
      bus(1'b1, D, 8'h01);
    end
    $display("halt done");
  endtask
  task t_irq;
    bus(1'b1, S, 8'h01);
    rd(S, 8'h00);
    bus(1'b1, M, 8'h01); w(2); chk("irq_off", {7'h0, irq}, 8'h00);
    intv(3'h7);
    rd(S, 8'h01); chk("irq_on", {7'h0, irq}, 8'h01);
    bus(1'b1, M, 8'h00); w(2); chk("irq_mask", {7'h0, irq}, 8'h00);
    bus(1'b1, S, 8'h01); rd(S, 8'h00);
    $display("irq done");
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Tests need about ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; lf = 1'b0;
    adr = 16'h0000; wdat = 32'h0; ticks = 0; error_cnt = 0; cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset(); t_codes(); t_gate(); t_restart(); t_halt(); t_irq();
    results();
  end
endmodule
